// >>> src/wake_mac_if_consts.vh
`ifndef WAKE_MAC_IF_CONSTS_VH
`define WAKE_MAC_IF_CONSTS_VH
// =====================================
// register indices, byte address = index * 4
`define IDX_SKEW 6'h14
`define IDX_ADDR_LO 6'h15
`define IDX_ADDR_MID 6'h16
`define IDX_ADDR_HI 6'h17
`define IDX_PWD_LO 6'h18
`define IDX_PWD_MID 6'h19
`define IDX_PWD_HI 6'h1a
`define IDX_WCTRL 6'h1b
`define IDX_IRQ_STAT 6'h20
`define IDX_IRQ_MASK 6'h21
`define IDX_SOFT 6'h22
// =====================================
// reset values and writable bits
`define SKEW_RST 16'h0000
`define SKEW_WMASK 16'h90ff
`define WCTRL_RST 16'h0ff0
`define WCTRL_WMASK 16'hcff1
`define WORD_RST 16'h0000
`define FULL_WMASK 16'hffff
// =====================================
// field positions
`define SKEW_FLF2 15
`define SKEW_SOF 12
`define SKEW_RXREV 7
`define SKEW_RXDLY_HI 6
`define SKEW_RXDLY_LO 4
`define SKEW_TXREV 3
`define SKEW_TXDLY_HI 2
`define SKEW_TXDLY_LO 0
`define WC_PWD_EN 15
`define WC_PWD_SHORT 14
`define WC_REP_HI 11
`define WC_REP_LO 8
`define WC_EDGE_HI 7
`define WC_EDGE_LO 5
`define WC_REFCLK 4
`define WC_MDINT 0
`define IRQ_MAGIC 0
`define IRQ_FRAME 1
`define IRQ_W 2
`define SOFT_RST_BIT 0
// =====================================
// bus answers and magic packet layout
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define SYNC_BYTE 8'hff
`define SYNC_LEN 3'd6
`define LAST_BYTE 3'd5
`define PWD_SHORT_START 3'd2
`define PWD_FULL_START 3'd0
`endif

// >>> src/magic_matcher.v
`timescale 1ns/10ps
`include "wake_mac_if_consts.vh"
module magic_matcher (
  input wire aclk,
  input wire aresetn,
  input wire soft_rst,
  input wire byte_stb,
  input wire [7:0] byte_data,
  input wire frame_end,
  input wire [47:0] station_addr,
  input wire [47:0] password,
  input wire [3:0] rep_code,
  input wire pwd_en,
  input wire pwd_short,
  output wire in_frame,
  output wire magic_hit
);
  localparam ST_SYNC = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_PWD = 2'd2;
  localparam ST_HIT = 2'd3;
  reg [1:0] state_ff, nxt_state;
  reg [2:0] ff_cnt_ff, nxt_ff_cnt;
  reg [2:0] idx_ff, nxt_idx;
  reg [3:0] rep_ff, nxt_rep;
  reg hit_ff, nxt_hit;
  reg frame_ff, nxt_frame;
  // first byte on the wire is the most significant one
  wire [5:0] sel = 6'd40 - {idx_ff, 3'b000};
  wire [7:0] addr_byte = station_addr[sel +: 8];
  wire [7:0] pwd_byte = password[sel +: 8];
  wire is_sync = (byte_data == `SYNC_BYTE);
  wire [2:0] restart_cnt = is_sync ? 3'd1 : 3'd0;
  assign magic_hit = hit_ff;
  assign in_frame = frame_ff;
  // =====================================
  // pattern search
  always @* begin
    nxt_state = state_ff;
    nxt_ff_cnt = ff_cnt_ff;
    nxt_idx = idx_ff;
    nxt_rep = rep_ff;
    nxt_frame = frame_ff;
    if (frame_end) begin
      nxt_state = ST_SYNC;
      nxt_ff_cnt = 3'd0;
      nxt_frame = 1'b0;
    end else if (byte_stb) begin
      nxt_frame = 1'b1;
      case (state_ff)
        ST_SYNC: begin
          nxt_ff_cnt = is_sync ? ff_cnt_ff + 3'd1 : 3'd0; // [R10]
          if (is_sync && ff_cnt_ff == `SYNC_LEN - 3'd1) begin
            nxt_state = ST_ADDR;
            nxt_idx = 3'd0;
            nxt_rep = 4'd0;
          end
        end
        ST_ADDR: begin
          if (byte_data == addr_byte) begin
            nxt_idx = idx_ff + 3'd1;
            if (idx_ff == `LAST_BYTE) begin
              nxt_idx = 3'd0;
              nxt_rep = rep_ff + 4'd1;
              if (rep_ff == rep_code) begin // [R6]
                nxt_state = pwd_en ? ST_PWD : ST_HIT; // [R7]
                nxt_idx = pwd_short ? `PWD_SHORT_START : `PWD_FULL_START; // [R10]
              end
            end
          end else if (!(idx_ff == 3'd0 && rep_ff == 4'd0 && is_sync)) begin
            nxt_state = ST_SYNC;
            nxt_ff_cnt = restart_cnt;
          end
        end
        ST_PWD: begin
          if (byte_data == pwd_byte) begin
            nxt_idx = idx_ff + 3'd1;
            if (idx_ff == `LAST_BYTE) nxt_state = ST_HIT;
          end else begin
            nxt_state = ST_SYNC;
            nxt_ff_cnt = restart_cnt;
          end
        end
        default: nxt_state = ST_HIT;
      endcase
    end
    nxt_hit = (nxt_state == ST_HIT) && (state_ff != ST_HIT);
  end
  always @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      state_ff <= ST_SYNC;
      ff_cnt_ff <= 3'd0;
      idx_ff <= 3'd0;
      rep_ff <= 4'd0;
      hit_ff <= 1'b0;
      frame_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ff_cnt_ff <= nxt_ff_cnt;
      idx_ff <= nxt_idx;
      rep_ff <= nxt_rep;
      hit_ff <= nxt_hit;
      frame_ff <= nxt_frame;
    end
  end
endmodule

// >>> src/wake_magic_and_mac_if_ctrl.v
// What this block does
// R1 - receive reversal bit flips rx data line order: four lines RGMII, eight otherwise
// R2 - transmit reversal bit flips tx data line order; clear means straight mapping
// R3 - three-bit rx and tx clock delay codes select 0.2 to 3.4 ns, default 000
// R4 - 48-bit wake station address in three 16-bit writable words, low word first
// R5 - station address and password words reset to zero
// R6 - four-bit repetition code plus one gives required address copies, reset 1111
// R7 - password enable adds password match; length bit clear 6 bytes, set 4 bytes
// R8 - 48-bit password held in three 16-bit words, ascending order
// R9 - reference clock output driven only while its enable bit is set, reset set
// R10 - magic packet is six 0xff then address copies; short password uses low 32 bits
// R11 - sticky fields survive software reset, cleared only by hardware reset
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "wake_mac_if_consts.vh"
module wake_magic_and_mac_if_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire link_clk,
  input wire link_dv,
  input wire [7:0] link_data,
  input wire rgmii_mode,
  output wire [7:0] mac_rxd,
  output wire mac_rx_dv,
  input wire [7:0] mac_txd,
  input wire mac_tx_en,
  output wire [7:0] line_txd,
  output wire line_tx_en,
  output wire [2:0] rx_clk_delay_sel,
  output wire [2:0] tx_clk_delay_sel,
  output wire flf2_enable,
  output wire sof_enable,
  output wire [2:0] pad_edge_rate,
  output wire mdint_cmos_drive,
  output wire reduced_if_ref_clock_out,
  output wire reduced_if_ref_clock_oe_n,
  output wire wake_on_lan_irq
);
  // =====================================
  // registers
  reg [15:0] skew_ff, wctrl_ff;
  reg [15:0] addr_lo_ff, addr_mid_ff, addr_hi_ff;
  reg [15:0] pwd_lo_ff, pwd_mid_ff, pwd_hi_ff;
  reg [`IRQ_W-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat;
  reg soft_rst_ff;
  reg [7:0] aw_addr_ff;
  reg aw_held_ff, w_held_ff, bvalid_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [1:0] bresp_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg rvalid_ff;
  reg [31:0] rd_word;
  reg rd_ok;
  reg wr_ok;
  // =====================================
  // pin synchronisers: two flops before any use
  localparam SYNC_W = 20;
  wire [SYNC_W-1:0] pins_raw;
  reg [SYNC_W-1:0] pins_meta_ff, pins_ff;
  assign pins_raw = {link_clk, link_dv, link_data, mac_tx_en, mac_txd, rgmii_mode};
  wire link_clk_s = pins_ff[19];
  wire link_dv_s = pins_ff[18];
  wire [7:0] link_data_s = pins_ff[17:10];
  wire tx_en_s = pins_ff[9];
  wire [7:0] txd_s = pins_ff[8:1];
  wire rgmii_s = pins_ff[0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta_ff <= {SYNC_W{1'b0}};
      pins_ff <= {SYNC_W{1'b0}};
    end else begin
      pins_meta_ff <= pins_raw;
      pins_ff <= pins_meta_ff;
    end
  end
  // =====================================
  // link edge finder and frame tracking
  reg link_clk_q_ff, dv_last_ff;
  wire link_rise = link_clk_s && !link_clk_q_ff;
  wire byte_stb = link_rise && link_dv_s;
  wire frame_end = link_rise && !link_dv_s && dv_last_ff;
  always @(posedge aclk) begin
    if (!aresetn || soft_rst_ff) begin
      link_clk_q_ff <= 1'b0;
      dv_last_ff <= 1'b0;
    end else begin
      link_clk_q_ff <= link_clk_s;
      if (link_rise) dv_last_ff <= link_dv_s;
    end
  end
  // =====================================
  // data line reordering toward and from the mac
  wire rx_rev = skew_ff[`SKEW_RXREV];
  wire tx_rev = skew_ff[`SKEW_TXREV];
  wire [7:0] rx_map, tx_map;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
      if (gi < 4) begin : g_lo
        assign rx_map[gi] = !rx_rev ? link_data_s[gi] :
          (rgmii_s ? link_data_s[3-gi] : link_data_s[7-gi]); // [R1]
        assign tx_map[gi] = !tx_rev ? txd_s[gi] :
          (rgmii_s ? txd_s[3-gi] : txd_s[7-gi]); // [R2]
      end else begin : g_hi
        assign rx_map[gi] = (rx_rev && !rgmii_s) ? link_data_s[7-gi] : link_data_s[gi]; // [R1]
        assign tx_map[gi] = (tx_rev && !rgmii_s) ? txd_s[7-gi] : txd_s[gi]; // [R2]
      end
    end
  endgenerate
  reg [7:0] mac_rxd_ff, line_txd_ff;
  reg mac_rx_dv_ff, line_tx_en_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      mac_rxd_ff <= 8'h00;
      mac_rx_dv_ff <= 1'b0;
      line_txd_ff <= 8'h00;
      line_tx_en_ff <= 1'b0;
    end else begin
      if (link_rise) begin
        mac_rxd_ff <= rx_map;
        mac_rx_dv_ff <= link_dv_s;
      end
      line_txd_ff <= tx_map;
      line_tx_en_ff <= tx_en_s;
    end
  end
  assign mac_rxd = mac_rxd_ff;
  assign mac_rx_dv = mac_rx_dv_ff;
  assign line_txd = line_txd_ff;
  assign line_tx_en = line_tx_en_ff;
  // =====================================
  // magic packet search
  wire magic_hit, in_frame;
  magic_matcher u_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .soft_rst(soft_rst_ff),
    .byte_stb(byte_stb),
    .byte_data(link_data_s),
    .frame_end(frame_end),
    .station_addr({addr_hi_ff, addr_mid_ff, addr_lo_ff}), // [R4]
    .password({pwd_hi_ff, pwd_mid_ff, pwd_lo_ff}), // [R8]
    .rep_code(wctrl_ff[`WC_REP_HI:`WC_REP_LO]), // [R6]
    .pwd_en(wctrl_ff[`WC_PWD_EN]), // [R7]
    .pwd_short(wctrl_ff[`WC_PWD_SHORT]), // [R7]
    .in_frame(in_frame),
    .magic_hit(magic_hit)
  );
  // =====================================
  // reference clock output
  reg ref_clk_ff, ref_oe_n_ff;
  wire ref_en = wctrl_ff[`WC_REFCLK];
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_clk_ff <= 1'b0;
      ref_oe_n_ff <= 1'b1;
    end else begin
      ref_clk_ff <= ref_en ? !ref_clk_ff : 1'b0; // [R9]
      ref_oe_n_ff <= !ref_en; // [R9]
    end
  end
  assign reduced_if_ref_clock_out = ref_clk_ff;
  assign reduced_if_ref_clock_oe_n = ref_oe_n_ff;
  // =====================================
  // axi4-lite write channel
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] st;
    input [15:0] wm;
    reg [15:0] nw;
    begin
      nw = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
      merge = (nw & wm) | (old & ~wm);
    end
  endfunction
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  wire wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [5:0] wr_idx = aw_addr_ff[7:2];
  always @* begin
    case (wr_idx)
      `IDX_SKEW, `IDX_ADDR_LO, `IDX_ADDR_MID, `IDX_ADDR_HI,
      `IDX_PWD_LO, `IDX_PWD_MID, `IDX_PWD_HI, `IDX_WCTRL,
      `IDX_IRQ_STAT, `IDX_IRQ_MASK, `IDX_SOFT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bresp_ff <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  // =====================================
  // sticky configuration, hardware reset only except the flf2 enable bit
  wire wr_lo = wr_fire && wstrb_ff[0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      skew_ff <= `SKEW_RST; // [R3]
      wctrl_ff <= `WCTRL_RST; // [R6] [R9]
      addr_lo_ff <= `WORD_RST; // [R5]
      addr_mid_ff <= `WORD_RST; // [R5]
      addr_hi_ff <= `WORD_RST; // [R5]
      pwd_lo_ff <= `WORD_RST; // [R5]
      pwd_mid_ff <= `WORD_RST; // [R5]
      pwd_hi_ff <= `WORD_RST; // [R5]
    end else begin
      // flf2 enable is the only non-sticky field here
      if (soft_rst_ff) skew_ff[`SKEW_FLF2] <= 1'b0; // [R11]
      if (wr_fire) begin
        case (wr_idx)
          `IDX_SKEW: skew_ff <= merge(skew_ff, wdata_ff, wstrb_ff, `SKEW_WMASK);
          `IDX_ADDR_LO: addr_lo_ff <= merge(addr_lo_ff, wdata_ff, wstrb_ff, `FULL_WMASK); // [R4]
          `IDX_ADDR_MID: addr_mid_ff <= merge(addr_mid_ff, wdata_ff, wstrb_ff, `FULL_WMASK);
          `IDX_ADDR_HI: addr_hi_ff <= merge(addr_hi_ff, wdata_ff, wstrb_ff, `FULL_WMASK);
          `IDX_PWD_LO: pwd_lo_ff <= merge(pwd_lo_ff, wdata_ff, wstrb_ff, `FULL_WMASK); // [R8]
          `IDX_PWD_MID: pwd_mid_ff <= merge(pwd_mid_ff, wdata_ff, wstrb_ff, `FULL_WMASK);
          `IDX_PWD_HI: pwd_hi_ff <= merge(pwd_hi_ff, wdata_ff, wstrb_ff, `FULL_WMASK);
          `IDX_WCTRL: wctrl_ff <= merge(wctrl_ff, wdata_ff, wstrb_ff, `WCTRL_WMASK);
          default: skew_ff <= skew_ff;
        endcase
      end
    end
  end
  assign rx_clk_delay_sel = skew_ff[`SKEW_RXDLY_HI:`SKEW_RXDLY_LO]; // [R3]
  assign tx_clk_delay_sel = skew_ff[`SKEW_TXDLY_HI:`SKEW_TXDLY_LO]; // [R3]
  assign flf2_enable = skew_ff[`SKEW_FLF2];
  assign sof_enable = skew_ff[`SKEW_SOF];
  assign pad_edge_rate = wctrl_ff[`WC_EDGE_HI:`WC_EDGE_LO];
  assign mdint_cmos_drive = wctrl_ff[`WC_MDINT];
  // =====================================
  // soft reset and interrupts, cleared by soft reset too
  wire [`IRQ_W-1:0] irq_ev;
  wire [`IRQ_W-1:0] irq_clr;
  assign irq_ev = {frame_end, magic_hit};
  assign irq_clr = (wr_lo && wr_idx == `IDX_IRQ_STAT) ? wdata_ff[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  always @* begin
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_ff <= 1'b0;
      irq_stat_ff <= {`IRQ_W{1'b0}};
      irq_mask_ff <= {`IRQ_W{1'b0}};
    end else begin
      soft_rst_ff <= wr_lo && wr_idx == `IDX_SOFT && wdata_ff[`SOFT_RST_BIT]; // [R11]
      if (soft_rst_ff) begin
        irq_stat_ff <= {`IRQ_W{1'b0}};
        irq_mask_ff <= {`IRQ_W{1'b0}};
      end else begin
        irq_stat_ff <= nxt_irq_stat;
        if (wr_lo && wr_idx == `IDX_IRQ_MASK) irq_mask_ff <= wdata_ff[`IRQ_W-1:0];
      end
    end
  end
  assign wake_on_lan_irq = |(irq_stat_ff & irq_mask_ff);
  // =====================================
  // axi4-lite read channel
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  always @* begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (rd_idx)
      `IDX_SKEW: rd_word[15:0] = skew_ff;
      `IDX_ADDR_LO: rd_word[15:0] = addr_lo_ff;
      `IDX_ADDR_MID: rd_word[15:0] = addr_mid_ff;
      `IDX_ADDR_HI: rd_word[15:0] = addr_hi_ff;
      `IDX_PWD_LO: rd_word[15:0] = pwd_lo_ff;
      `IDX_PWD_MID: rd_word[15:0] = pwd_mid_ff;
      `IDX_PWD_HI: rd_word[15:0] = pwd_hi_ff;
      `IDX_WCTRL: rd_word[15:0] = wctrl_ff;
      `IDX_IRQ_STAT: rd_word[`IRQ_W-1:0] = irq_stat_ff;
      `IDX_IRQ_MASK: rd_word[`IRQ_W-1:0] = irq_mask_ff;
      `IDX_SOFT: rd_word[2:1] = {rgmii_s, in_frame};
      default: rd_ok = 1'b0;
    endcase
  end
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

// >>> dv/wake_magic_and_mac_if_ctrl_sva.sv
`timescale 1ns/10ps
module wake_magic_and_mac_if_ctrl_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire link_clk,
  input wire [7:0] mac_rxd,
  input wire mac_tx_en,
  input wire line_tx_en,
  input wire [2:0] rx_clk_delay_sel,
  input wire [2:0] tx_clk_delay_sel,
  input wire [2:0] pad_edge_rate,
  input wire reduced_if_ref_clock_out,
  input wire reduced_if_ref_clock_oe_n,
  input wire wake_on_lan_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ====================================
  // register bus
  AST_WR_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer missing");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_RD_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_CFG_ON_WRITE:
    assert property (!$stable({rx_clk_delay_sel, tx_clk_delay_sel, pad_edge_rate})
      |-> $rose(s_axi_bvalid)) else $error("config output moved without write");
  // ====================================
  // reference clock and data paths
  AST_REFCLK_QUIET:
    assert property (reduced_if_ref_clock_oe_n |-> !reduced_if_ref_clock_out)
    else $error("ref clock active while disabled");
  AST_REFCLK_RUN:
    assert property (!reduced_if_ref_clock_oe_n && !$past(reduced_if_ref_clock_oe_n)
      |-> reduced_if_ref_clock_out != $past(reduced_if_ref_clock_out))
    else $error("ref clock stalled while enabled");
  AST_TX_LATENCY:
    assert property (line_tx_en == $past(mac_tx_en, 3)) else $error("tx enable latency");
  AST_RX_ON_LINK_EDGE:
    assert property (!$stable(mac_rxd) |-> $past(link_clk, 2))
    else $error("rx data moved off link edge");
  cover property ($rose(wake_on_lan_irq));
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property ($rose(reduced_if_ref_clock_oe_n));
endmodule
bind wake_magic_and_mac_if_ctrl wake_magic_and_mac_if_ctrl_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_clk(link_clk),
  .mac_rxd(mac_rxd), .mac_tx_en(mac_tx_en), .line_tx_en(line_tx_en),
  .rx_clk_delay_sel(rx_clk_delay_sel), .tx_clk_delay_sel(tx_clk_delay_sel),
  .pad_edge_rate(pad_edge_rate), .reduced_if_ref_clock_out(reduced_if_ref_clock_out),
  .reduced_if_ref_clock_oe_n(reduced_if_ref_clock_oe_n), .wake_on_lan_irq(wake_on_lan_irq));

// >>> dv/mac_link_partner.sv
`timescale 1ns/10ps
module mac_link_partner (
  output logic link_clk,
  output logic link_dv,
  output logic [7:0] link_data
);
  initial begin
    link_clk = 1'b0;
    link_dv = 1'b0;
    link_data = 8'h00;
  end
  // one byte per rise, data held a full 320 ns period around it
  task automatic send_byte(input logic [7:0] b);
    #13 link_data = b;
    link_dv = 1'b1;
    #100 link_clk = 1'b1;
    #160 link_clk = 1'b0;
    #47;
  endtask
  // closing rise with valid low, data no longer held, then the clock stands still
  task automatic end_frame();
    #13 link_dv = 1'b0;
    link_data = ~link_data;
    #100 link_clk = 1'b1;
    #160 link_clk = 1'b0;
    #47;
  endtask
endmodule

// >>> dv/wake_magic_and_mac_if_ctrl_tb.sv
`timescale 1ns/10ps
`include "wake_mac_if_consts.vh"
module wake_magic_and_mac_if_ctrl_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mac_txd, mac_rxd, line_txd, link_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic link_clk, link_dv, rgmii_mode, mac_tx_en, line_tx_en, irq, ref_out, ref_oe_n, b_prev;
  logic [2:0] rx_dly, tx_dly;
  logic [2:0] pad;
  logic rx_dv, flf2, sof, mdint;
  int error_cnt, cmp_count;
  int cyc = 0;
  localparam logic [47:0] station_val = 48'h0a1b2c3d4e5f;
  localparam logic [47:0] pw_val = 48'h5566a1b2c3d4;
  localparam logic [95:0] words = {pw_val, station_val};
  int cp_tab [5] = '{1, 2, 2, 2, 2};
  int pw_tab [5] = '{0, 0, 6, 4, 4};
  logic [15:0] ctl_tab [5] = '{16'h01f0, 16'h01f0, 16'h81f0, 16'h81f0, 16'hc1f0};
  logic hit_tab [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  wake_magic_and_mac_if_ctrl dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_clk(link_clk),
    .link_dv(link_dv), .link_data(link_data), .rgmii_mode(rgmii_mode), .mac_rxd(mac_rxd),
    .mac_rx_dv(rx_dv), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .line_txd(line_txd),
    .line_tx_en(line_tx_en), .rx_clk_delay_sel(rx_dly), .tx_clk_delay_sel(tx_dly),
    .flf2_enable(flf2), .sof_enable(sof), .pad_edge_rate(pad), .mdint_cmos_drive(mdint),
    .reduced_if_ref_clock_out(ref_out), .reduced_if_ref_clock_oe_n(ref_oe_n),
    .wake_on_lan_irq(irq));
  mac_link_partner u_link (.link_clk(link_clk), .link_dv(link_dv), .link_data(link_data));
  // ====================================
  // clock and run limit
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ====================================
  // helpers
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er = 2'b00);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input logic [1:0] er = 2'b00);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", {16'h0000, exp}, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic hw_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  function automatic logic [7:0] remap(input logic rev, input logic mode, input logic [7:0] b);
    logic [7:0] r;
    r = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
    if (!rev) return b;
    if (mode) return {b[7:4], r[7:4]};
    return r;
  endfunction
  task automatic send_magic(input int copies, input int npwd);
    for (int i = 0; i < 6; i++) u_link.send_byte(`SYNC_BYTE);
    for (int c = 0; c < copies; c++)
      for (int i = 5; i >= 0; i--) u_link.send_byte(station_val[8*i +: 8]);
    for (int i = npwd - 1; i >= 0; i--) u_link.send_byte(pw_val[8*i +: 8]);
    u_link.end_frame();
    repeat (4) @(posedge aclk);
  endtask
  // ====================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    {rgmii_mode, mac_tx_en} = 2'b00;
    mac_txd = 8'h00;
    hw_reset();
    rd(`IDX_SKEW, 16'h0000);
    for (int i = 0; i < 6; i++) rd(6'(`IDX_ADDR_LO + i), 16'h0000);
    rd(`IDX_WCTRL, 16'h0ff0);
    chk("ref_oe_n", 0, ref_oe_n);
    wr(`IDX_SKEW, 16'hffff);
    rd(`IDX_SKEW, 16'h90ff);
    wr(`IDX_WCTRL, 16'hffff);
    rd(`IDX_WCTRL, 16'hcff1);
    for (int i = 0; i < 6; i++) wr(6'(`IDX_ADDR_LO + i), words[16*i +: 16]);
    for (int i = 0; i < 6; i++) rd(6'(`IDX_ADDR_LO + i), words[16*i +: 16]);
    wr(6'h1c, 16'hffff, `RESP_SLVERR);
    rd(6'h1c, 16'h0000, `RESP_SLVERR);
    for (int c = 0; c < 8; c++) begin
      wr(`IDX_SKEW, {9'h000, 3'(c), 1'b0, 3'(7 - c)});
      chk("rx_dly", c, rx_dly);
      chk("tx_dly", 7 - c, tx_dly);
    end
    wr(`IDX_WCTRL, 16'h0fe0);
    repeat (3) @(posedge aclk);
    chk("ref_oe_n", 1, ref_oe_n);
    chk("ref_out", 0, ref_out);
    wr(`IDX_WCTRL, 16'h0ff1);
    repeat (3) @(posedge aclk);
    b_prev = ref_out;
    @(posedge aclk);
    chk("ref_out", !b_prev, ref_out);
    for (int k = 0; k < 4; k++) begin
      rgmii_mode <= k[0];
      wr(`IDX_SKEW, k[1] ? 16'h0088 : 16'h0000);
      mac_txd <= 8'h1e;
      mac_tx_en <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("line_txd", remap(k[1], k[0], 8'h1e), line_txd);
      chk("line_tx_en", 1, line_tx_en);
      u_link.send_byte(8'hc5);
      chk("mac_rxd", remap(k[1], k[0], 8'hc5), mac_rxd);
      chk("mac_rx_dv", 1, rx_dv);
      u_link.end_frame();
      chk("mac_rx_dv", 0, rx_dv);
    end
    mac_tx_en <= 1'b0;
    wr(`IDX_SKEW, 16'h90ff);
    chk("cfg_pins", 6'h3f, {flf2, sof, pad, mdint});
    wr(`IDX_IRQ_MASK, 16'h0003);
    wr(`IDX_SOFT, 16'h0001);
    repeat (3) @(posedge aclk);
    rd(`IDX_SKEW, 16'h10ff);
    chk("cfg_pins", 6'h1f, {flf2, sof, pad, mdint});
    rd(`IDX_ADDR_LO, station_val[15:0]);
    rd(`IDX_IRQ_MASK, 16'h0000);
    rd(`IDX_SOFT, 16'h0004);
    wr(`IDX_IRQ_MASK, 16'h0001);
    for (int t = 0; t < 5; t++) begin
      wr(`IDX_WCTRL, ctl_tab[t]);
      send_magic(cp_tab[t], pw_tab[t]);
      rd(`IDX_IRQ_STAT, {14'h0000, 1'b1, hit_tab[t]});
      chk("irq", hit_tab[t], irq);
      wr(`IDX_IRQ_STAT, 16'h0003);
      chk("irq", 0, irq);
    end
    hw_reset();
    rd(`IDX_ADDR_HI, 16'h0000);
    rd(`IDX_WCTRL, 16'h0ff0);
    stop_test();
  end
endmodule
